// >>> src/cs_access_check.sv
/*
  Control store access check: decodes a search engine reference, checks the
  memory identifier and object shape, expands it into single location
  accesses and raises illegal and range flags.
  Assumes the memory side grants each location with MEM_GNT and that other
  requesters are arbitrated outside this block.
*/
`timescale 1ns/1ps
module cs_access_check
  import cs_access_pkg::*;
(
  input  wire logic                   MCLK,
  input  wire logic                   RSTN,
  input  wire logic                   REQ_VALID,
  input  wire logic [ADDR_W-1:0]      REQ_ADDR,
  input  wire logic [SHAPE_W-1:0]     REQ_HEIGHT,
  input  wire logic [SHAPE_W-1:0]     REQ_WIDTH,
  input  wire logic                   REQ_WRITE,
  input  wire logic [GROUP_W-1:0]     REQ_GROUP,
  input  wire logic                   MEM_GNT,
  input  wire logic                   BUS_VALID,
  input  wire logic [BYTE_ADDR_W-1:0] BUS_ADDR,
  input  wire logic [RADDR_W-1:0]     REG_ADDR,
  input  wire logic [DATA_W-1:0]      REG_WDATA,
  input  wire logic                   REG_WR,
  input  wire logic                   REG_RD,
  output logic                        REQ_READY,
  output logic                        DONE,
  output logic                        FAILED_RESULT,
  output logic                        MEM_REQ,
  output logic [ADDR_W-1:0]           MEM_ADDR,
  output logic                        MEM_WRITE,
  output logic                        BUS_CS_VALID,
  output logic [ADDR_W-1:0]           BUS_CS_ADDR,
  output logic [THREADS-1:0]          SINGLE_STEP,
  output logic                        IRQ_CLASS3,
  output logic [DATA_W-1:0]           REG_RDATA
);

  //////////////////////////////////////////////////////////////////////////
  // Registers and request state.
  logic [DATA_W-1:0]   ctrl_ff, min_ff, max_ff, mask_ff, step_ff;
  logic [2:0]          class3_ff;
  logic [GROUP_W:0]    bounds_ff;
  walk_t               st_ff;
  logic [ADDR_W-1:0]   base_ff;
  logic [SHAPE_W-1:0]  hgt_ff, wid_ff, hcnt_ff, wcnt_ff;
  logic                wr_ff;

  // Offset alignment mask for a given height: 1,2,4,4,8,8,8,8.
  // Only the low three offset bits matter, because no legal height needs a
  // boundary coarser than eight locations. Heights of nine and above fall
  // into the default arm and are refused later by the per-memory height limit.
  function automatic logic [2:0] align_mask(input logic [SHAPE_W-1:0] h);
    case (h)
      4'h1:    align_mask = 3'h0;
      4'h2:    align_mask = 3'h1;
      4'h3,
      4'h4:    align_mask = 3'h3;
      default: align_mask = 3'h7;
    endcase
  endfunction

  // True when a control store address falls within the programmed limits.
  // The limits are full words and the address is zero-extended, so a limit
  // programmed above the 26-bit space still compares the way software expects.
  function automatic logic in_range(input logic [ADDR_W-1:0] a,
                                    input logic [DATA_W-1:0] lo,
                                    input logic [DATA_W-1:0] hi);
    in_range = ({6'h0, a} >= lo) && ({6'h0, a} <= hi);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Request decode and legality check, done combinationally on the request.
  logic [MID_W-1:0]  mid;
  logic [BANK_W-1:0] bank;
  logic [OFS_W-1:0]  ofs;
  logic [VBA_W-1:0]  last_vba;
  logic [9:0]        loc_bits;
  // The shape product is kept wide: a ten-bit product wraps at 1024 bits and
  // would let an oversized object through the size limit.
  logic [14:0]       obj_bits;
  logic              legal;
  logic              dbl;

  assign mid  = REQ_ADDR[ADDR_W-1 -: MID_W];
  assign bank = REQ_ADDR[OFS_W +: BANK_W];
  assign ofs  = REQ_ADDR[OFS_W-1:0];
  assign dbl  = ctrl_ff[CTRL_DOUBLE];
  // The last virtual bank an object touches decides whether it crosses into a
  // neighbouring memory. The sum wraps past identifier 1111 on purpose, so such
  // an object lands on the null identifier and is refused.
  assign last_vba = REQ_ADDR[ADDR_W-1 -: VBA_W] + {2'h0, REQ_WIDTH} - 6'h1;
  assign obj_bits = 15'(loc_bits) * 15'(REQ_HEIGHT) * 15'(REQ_WIDTH);

  // Identifier, shape, alignment and crossing checks per memory.
  // Everything is judged on the offered request, so the verdict is ready at
  // the accept edge and a refused command never reaches the memory side.
  // A zero height or width is treated as an illegal shape.
  always_comb begin
    legal    = 1'b0;
    loc_bits = 10'(BITS_SINGLE);
    if (REQ_HEIGHT != 4'h0 && REQ_WIDTH != 4'h0 &&
        (ofs[2:0] & align_mask(REQ_HEIGHT)) == 3'h0) begin
      case (mid)
        MID_INTERNAL: begin
          if (bank == BANK_WIDE) begin
            loc_bits = 10'(BITS_WIDE);
            legal = REQ_HEIGHT <= MAX_H_WIDE && REQ_WIDTH == 4'h1 &&
                    ofs[OFS_W-1:INT_OFS_W] == '0;
          end else if (bank == BANK_NARROW) begin
            loc_bits = 10'(BITS_NARROW);
            legal = REQ_HEIGHT <= MAX_H_NARROW && REQ_WIDTH == 4'h1 &&
                    ofs[OFS_W-1:INT_OFS_W] == '0;
          end
        end
        MID_ZBT: begin
          loc_bits = 10'(BITS_NARROW);
          legal = bank == 2'h0 && REQ_HEIGHT <= MAX_H_NARROW &&
                  REQ_WIDTH == 4'h1 &&
                  (ctrl_ff[CTRL_ZBTNEW] || !ofs[ZBT_OFS_OLD_W]);
        end
        MID_DRAM0: begin
          loc_bits = dbl ? 10'(BITS_WIDE) : 10'(BITS_SINGLE);
          if (dbl)
            legal = last_vba[VBA_W-1 -: MID_W] == MID_DRAM0;
          else
            legal = last_vba[VBA_W-1 -: MID_W] == MID_DRAM0 ||
                    last_vba[VBA_W-1 -: MID_W] == MID_DRAM1;
        end
        MID_DRAM1:
          legal = last_vba[VBA_W-1 -: MID_W] == MID_DRAM1 ||
                  last_vba[VBA_W-1 -: MID_W] == MID_DRAM2;
        MID_DRAM2:
          legal = last_vba[VBA_W-1 -: MID_W] == MID_DRAM2;
        MID_DRAM3:
          legal = last_vba[VBA_W-1 -: MID_W] == MID_DRAM3;
        4'hC, 4'hD, 4'hE, 4'hF:
          legal = last_vba[VBA_W-1 -: MID_W] == mid;
        default: legal = 1'b0;
      endcase
      // DRAM height limit is eight single-wide, four double-wide.
      if (mid[3] && REQ_HEIGHT > ((mid == MID_DRAM0 && dbl) ? MAX_H_WIDE
                                                           : MAX_H_NARROW))
        legal = 1'b0;
      if (obj_bits > 15'(MAX_BITS))
        legal = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Object walk: one command, many locations, height first.
  // Only one command is in flight; a new request waits in REQ_VALID until the
  // walk has returned to idle.
  logic accept;
  logic last_loc;
  assign accept   = REQ_VALID && st_ff == ST_IDLE;
  assign last_loc = hcnt_ff == hgt_ff - 4'h1 && wcnt_ff == wid_ff - 4'h1;

  // Sequencer state; the memory grant paces it so others are not blocked.
  // A stalled grant simply holds the walk, the store arbiter is free to serve
  // other requesters meanwhile, and the thread only sees the final done pulse.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      st_ff   <= ST_IDLE;
      base_ff <= '0;
      hgt_ff  <= '0;
      wid_ff  <= '0;
      hcnt_ff <= '0;
      wcnt_ff <= '0;
      wr_ff   <= 1'b0;
    end else begin
      case (st_ff)
        ST_IDLE: if (accept) begin
          base_ff <= REQ_ADDR;
          hgt_ff  <= REQ_HEIGHT;
          wid_ff  <= REQ_WIDTH;
          wr_ff   <= REQ_WRITE;
          hcnt_ff <= '0;
          wcnt_ff <= '0;
          st_ff   <= legal ? ST_RUN : ST_DONE;
        end
        ST_RUN: if (MEM_GNT) begin
          if (last_loc)
            st_ff <= ST_DONE;
          else if (hcnt_ff == hgt_ff - 4'h1) begin
            hcnt_ff <= '0;
            wcnt_ff <= wcnt_ff + 4'h1;
          end else
            hcnt_ff <= hcnt_ff + 4'h1;
        end
        ST_DONE: st_ff <= ST_IDLE;
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // Location address: bank steps by virtual bank, offset by height count.
  // Software keeps offsets from carrying into the bank bits, so the offset sum
  // is cut to twenty bits rather than rippling upward.
  logic [ADDR_W-1:0] loc_addr;
  assign loc_addr = {6'(base_ff[ADDR_W-1:OFS_W] + {2'h0, wcnt_ff}),
                     20'(base_ff[OFS_W-1:0] + {16'h0, hcnt_ff})};

  // Memory side outputs, registered.
  // MEM_ADDR is loaded one step ahead: on a grant it already moves to the next
  // location, so the request that follows carries the right address with no
  // gap cycle between locations.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      MEM_REQ   <= 1'b0;
      MEM_ADDR  <= '0;
      MEM_WRITE <= 1'b0;
    end else begin
      MEM_REQ   <= st_ff == ST_RUN && !(MEM_GNT && last_loc);
      MEM_ADDR  <= (MEM_GNT && !last_loc && st_ff == ST_RUN) ?
                   ((hcnt_ff == hgt_ff - 4'h1) ?
                    {6'(base_ff[ADDR_W-1:OFS_W] + {2'h0, wcnt_ff} + 6'h1),
                     base_ff[OFS_W-1:0]} :
                    {loc_addr[ADDR_W-1:OFS_W], 20'(loc_addr[OFS_W-1:0] + 20'h1)}) :
                   (accept ? REQ_ADDR : MEM_ADDR);
      MEM_WRITE <= accept ? REQ_WRITE : MEM_WRITE;
    end
  end

  // Command handshake: ready when idle, done with pass or failed result.
  // REQ_READY drops in the cycle after a request is offered and stays low until the walk is done,
  // so a request still held one cycle past its accept edge is never taken a second time.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      REQ_READY     <= 1'b1;
      DONE          <= 1'b0;
      FAILED_RESULT <= 1'b0;
    end else begin
      REQ_READY     <= st_ff == ST_IDLE ? !REQ_VALID : st_ff == ST_DONE;
      DONE          <= (accept && !legal) || (st_ff == ST_RUN && MEM_GNT && last_loc);
      FAILED_RESULT <= accept && !legal;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Shared DRAM translation for the processor bus: 8-byte units.
  // Byte bits 4:3 pick the bank, so consecutive 8-byte units rotate over the
  // four banks and the flat byte view matches the engine's view. Only the top
  // two identifier bits are fixed, since the shared group owns 1100 to 1111.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      BUS_CS_VALID <= 1'b0;
      BUS_CS_ADDR  <= '0;
    end else begin
      BUS_CS_VALID <= BUS_VALID;
      BUS_CS_ADDR  <= {2'b11, BUS_ADDR[BYTE_ADDR_W-1:BYTE_MID_LO],
                       BUS_ADDR[BYTE_OFS_LO-1:BYTE_BANK_LO],
                       BUS_ADDR[BYTE_OFS_HI:BYTE_OFS_LO]};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Range check on engine requests only; bus path never reaches it.
  // Only the base address is compared, which keeps the check to one cycle at
  // the cost of missing a hit that lies inside a multi-location object.
  logic range_hit;
  assign range_hit = accept &&
                     ((REQ_WRITE && ctrl_ff[CTRL_WRCHK]) ||
                      (!REQ_WRITE && ctrl_ff[CTRL_RDCHK])) &&
                     in_range(REQ_ADDR, min_ff, max_ff);
  logic illegal_hit;
  assign illegal_hit = accept && !legal;

  // Class 3 flags; a set in the same cycle as a clear wins.
  // Bit 0 has no source in this block and always reads back as zero.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      class3_ff <= '0;
    end else begin
      for (int i = 0; i < 3; i++)
        if (REG_WR && REG_ADDR == REG_CLASS3 && REG_WDATA[i])
          class3_ff[i] <= 1'b0;
      if (range_hit)
        class3_ff[FLAG_RANGE] <= 1'b1;
      if (illegal_hit)
        class3_ff[FLAG_ILLEGAL] <= 1'b1;
    end
  end

  // Offending group, valid bit on top; latest range exception wins.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN)
      bounds_ff <= '0;
    else if (range_hit)
      bounds_ff <= {1'b1, REQ_GROUP};
    else if (REG_WR && REG_ADDR == REG_BOUNDS)
      bounds_ff <= '0;
  end

  // Exception line and single-step forcing.
  // Single-step follows the flags, not the mask, so debugging works even while
  // the interrupt itself is masked off.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      IRQ_CLASS3  <= 1'b0;
      SINGLE_STEP <= '0;
    end else begin
      IRQ_CLASS3  <= |(class3_ff & mask_ff[2:0]);
      SINGLE_STEP <= (|class3_ff[FLAG_ILLEGAL:FLAG_RANGE]) ? step_ff : '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register writes.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_ff <= CTRL_RST;
      min_ff  <= '0;
      max_ff  <= '0;
      mask_ff <= '0;
      step_ff <= '0;
    end else if (REG_WR) begin
      case (REG_ADDR)
        REG_CTRL:    ctrl_ff <= REG_WDATA;
        REG_MIN:     min_ff  <= REG_WDATA;
        REG_MAX:     max_ff  <= REG_WDATA;
        REG_MASK3:   mask_ff <= REG_WDATA;
        REG_STEPSET: step_ff <= REG_WDATA;
        default: ;
      endcase
    end
  end

  // Register reads, data in the following cycle; unmapped reads zero.
  // The read data return to zero outside the read slot, so an idle bus never
  // shows stale register contents.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN)
      REG_RDATA <= '0;
    else if (REG_RD) begin
      case (REG_ADDR)
        REG_CTRL:    REG_RDATA <= {28'h0, ctrl_ff[3:0]};
        REG_MIN:     REG_RDATA <= min_ff;
        REG_MAX:     REG_RDATA <= max_ff;
        REG_CLASS3:  REG_RDATA <= {29'h0, class3_ff};
        REG_MASK3:   REG_RDATA <= {29'h0, mask_ff[2:0]};
        REG_BOUNDS:  REG_RDATA <= {28'h0, bounds_ff};
        REG_STEPSET: REG_RDATA <= step_ff;
        default:     REG_RDATA <= '0;
      endcase
    end else
      REG_RDATA <= '0;
  end

endmodule

// >>> src/cs_access_pkg.sv
/*
  Shared constants for the control store access check block: address layout,
  memory identifiers, shape limits and register map.
  Assumes a single 200 MHz clock domain and a plain register port.
*/
package cs_access_pkg;
  // Address layout.
  localparam int ADDR_W   = 26;
  localparam int MID_W    = 4;
  localparam int BANK_W   = 2;
  localparam int OFS_W    = 20;
  localparam int VBA_W    = 6;
  localparam int INT_OFS_W = 11;
  localparam int ZBT_OFS_OLD_W = 19;
  // Memory identifiers.
  localparam logic [3:0] MID_ZBT      = 4'h1;
  localparam logic [3:0] MID_INTERNAL = 4'h2;
  localparam logic [3:0] MID_DRAM0    = 4'h8;
  localparam logic [3:0] MID_DRAM1    = 4'h9;
  localparam logic [3:0] MID_DRAM2    = 4'hA;
  localparam logic [3:0] MID_DRAM3    = 4'hB;
  localparam logic [3:0] MID_SHARED0  = 4'hC;
  localparam logic [1:0] BANK_WIDE    = 2'h0;
  localparam logic [1:0] BANK_NARROW  = 2'h1;
  // Shared DRAM byte address layout.
  localparam int BYTE_ADDR_W  = 27;
  localparam int BYTE_BANK_LO = 3;
  localparam int BYTE_OFS_LO  = 5;
  localparam int BYTE_OFS_HI  = 24;
  localparam int BYTE_MID_LO  = 25;
  // Shape limits.
  localparam int SHAPE_W      = 4;
  localparam int MAX_BITS     = 512;
  localparam int BITS_NARROW  = 36;
  localparam int BITS_WIDE    = 128;
  localparam int BITS_SINGLE  = 64;
  localparam logic [3:0] MAX_H_NARROW = 4'h8;
  localparam logic [3:0] MAX_H_WIDE   = 4'h4;
  // Register port.
  localparam int RADDR_W = 4;
  localparam int DATA_W  = 32;
  localparam int THREADS = 32;
  localparam int GROUP_W = 3;
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_MIN     = 4'h1;
  localparam logic [3:0] REG_MAX     = 4'h2;
  localparam logic [3:0] REG_CLASS3  = 4'h3;
  localparam logic [3:0] REG_MASK3   = 4'h4;
  localparam logic [3:0] REG_BOUNDS  = 4'h5;
  localparam logic [3:0] REG_STEPSET = 4'h6;
  localparam int CTRL_DOUBLE = 0;
  localparam int CTRL_RDCHK  = 1;
  localparam int CTRL_WRCHK  = 2;
  localparam int CTRL_ZBTNEW = 3;
  localparam int FLAG_RANGE   = 1;
  localparam int FLAG_ILLEGAL = 2;
  localparam logic [31:0] CTRL_RST = 32'h0000_0008;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_DONE = 2'b10
  } walk_t;
endpackage

// >>> sim/cs_mem_model.sv
/*
  Memory side model: grants location requests after a varying stall.
  Assumes MEM_REQ is launched just after a rising MCLK edge and held.
*/
`timescale 1ns/1ps
module cs_mem_model (
  input  wire logic MCLK,
  input  wire logic RSTN,
  input  wire logic MEM_REQ,
  output logic      MEM_GNT
);
  logic [4:0] lfsr_ff;

  // Stall pattern, so that grants come both at once and late.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      lfsr_ff <= 5'h1F;
    end else begin
      lfsr_ff <= {lfsr_ff[3:0], lfsr_ff[4] ^ lfsr_ff[2]};
    end
  end

  // A grant only answers a standing request; an idle memory grants nothing.
  assign MEM_GNT = MEM_REQ & (lfsr_ff[1] | lfsr_ff[0]);
endmodule

// >>> sim/cs_access_check_sva.sv
/*
  Port checker for the control store access check block.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module cs_access_check_sva
  import cs_access_pkg::*;
(
  input wire logic                   MCLK,
  input wire logic                   RSTN,
  input wire logic                   REQ_VALID,
  input wire logic [ADDR_W-1:0]      REQ_ADDR,
  input wire logic [SHAPE_W-1:0]     REQ_HEIGHT,
  input wire logic [SHAPE_W-1:0]     REQ_WIDTH,
  input wire logic                   REQ_READY,
  input wire logic                   DONE,
  input wire logic                   FAILED_RESULT,
  input wire logic                   MEM_REQ,
  input wire logic [ADDR_W-1:0]      MEM_ADDR,
  input wire logic                   MEM_GNT,
  input wire logic                   BUS_VALID,
  input wire logic [BYTE_ADDR_W-1:0] BUS_ADDR,
  input wire logic                   BUS_CS_VALID,
  input wire logic [ADDR_W-1:0]      BUS_CS_ADDR,
  input wire logic                   REG_RD,
  input wire logic [DATA_W-1:0]      REG_RDATA
);
  wire logic acc;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);

  // A command is taken when it is offered to an idle block.
  assign acc = REQ_VALID && REQ_READY;

  a_fail_with_done: assert property (FAILED_RESULT |-> DONE)
    else $error("failed result without done");
  a_reserved_id: assert property (acc && REQ_ADDR[25:22] inside {[4'h3:4'h7]}
    |=> DONE && FAILED_RESULT) else $error("reserved id not refused");
  a_zbt_narrow: assert property (acc && REQ_ADDR[25:20] == 6'h04 && REQ_WIDTH == 4'h2
    |=> FAILED_RESULT) else $error("wide zbt object not refused");
  a_first_loc: assert property (acc && REQ_ADDR[25:22] == MID_DRAM1 && REQ_HEIGHT == 4'h1
    && REQ_WIDTH == 4'h1 |=> MEM_ADDR == $past(REQ_ADDR) ##1 MEM_REQ)
    else $error("first location wrong");
  a_req_hold: assert property (MEM_REQ && !MEM_GNT |=> MEM_REQ && $stable(MEM_ADDR))
    else $error("location request dropped");
  a_addr_step: assert property (MEM_REQ && MEM_GNT |=> DONE
    || MEM_ADDR == $past(MEM_ADDR) + 26'h1 || MEM_ADDR[25:20] == $past(MEM_ADDR[25:20]) + 6'h1)
    else $error("location step wrong");
  a_done_grant: assert property (DONE && !FAILED_RESULT |-> $past(MEM_REQ && MEM_GNT))
    else $error("done before last grant");
  a_busy_accept: assert property (acc |=> !REQ_READY)
    else $error("second command taken");
  a_bus_xlate: assert property (BUS_VALID |=> BUS_CS_VALID && BUS_CS_ADDR ==
    {MID_SHARED0 + $past(BUS_ADDR[26:25]), $past(BUS_ADDR[4:3]), $past(BUS_ADDR[24:5])})
    else $error("bus translation wrong");
  a_rdata_idle: assert property (!REG_RD |=> REG_RDATA == 32'h0000_0000)
    else $error("read data outside read slot");
endmodule

bind cs_access_check cs_access_check_sva cs_access_check_sva_inst (.MCLK, .RSTN, .REQ_VALID,
  .REQ_ADDR, .REQ_HEIGHT, .REQ_WIDTH, .REQ_READY, .DONE, .FAILED_RESULT, .MEM_REQ, .MEM_ADDR,
  .MEM_GNT, .BUS_VALID, .BUS_ADDR, .BUS_CS_VALID, .BUS_CS_ADDR, .REG_RD, .REG_RDATA);

// >>> sim/testbench.sv
/*
  Self-checking bench for the control store access check block.
  Assumes the memory model grants every location request within a few cycles.
*/
`timescale 1ns/1ps
module testbench;
  import cs_access_pkg::*;
  logic        MCLK = 0, RSTN = 0, REQ_VALID = 0, REQ_WRITE = 0, BUS_VALID = 0;
  logic        REG_WR = 0, REG_RD = 0, MEM_GNT, REQ_READY, DONE, FAILED_RESULT;
  logic        MEM_REQ, MEM_WRITE, BUS_CS_VALID, IRQ_CLASS3;
  logic [25:0] REQ_ADDR = 0, MEM_ADDR, BUS_CS_ADDR, rng;
  logic [3:0]  REQ_HEIGHT = 1, REQ_WIDTH = 1, REG_ADDR = 0, h, w;
  logic [2:0]  REQ_GROUP = 0, grp;
  logic [26:0] BUS_ADDR = 0, b;
  logic [31:0] REG_WDATA = 0, REG_RDATA, SINGLE_STEP, d, step;
  logic [33:0] bad_tab [11];
  int          seed = 61997, n_mismatch = 0, n_tests = 0;

  cs_access_check cs_access_check_inst (.MCLK, .RSTN, .REQ_VALID, .REQ_ADDR, .REQ_HEIGHT,
    .REQ_WIDTH, .REQ_WRITE, .REQ_GROUP, .MEM_GNT, .BUS_VALID, .BUS_ADDR, .REG_ADDR, .REG_WDATA,
    .REG_WR, .REG_RD, .REQ_READY, .DONE, .FAILED_RESULT, .MEM_REQ, .MEM_ADDR, .MEM_WRITE,
    .BUS_CS_VALID, .BUS_CS_ADDR, .SINGLE_STEP, .IRQ_CLASS3, .REG_RDATA);
  cs_mem_model cs_mem_model_inst (.MCLK(MCLK), .RSTN(RSTN), .MEM_REQ(MEM_REQ), .MEM_GNT(MEM_GNT));

  // Clock at 200 MHz.
  always #2.5 MCLK = ~MCLK;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge MCLK);
    REG_ADDR <= a;
    REG_WDATA <= v;
    REG_WR <= 1'b1;
    @(posedge MCLK);
    REG_WR <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge MCLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge MCLK);
    REG_RD <= 1'b0;
    #1 v = REG_RDATA;
  endtask

  task automatic settle();
    repeat (2) @(posedge MCLK);
    #1;
  endtask

  // Offers one command, then follows every granted location up to the done pulse.
  task automatic cmd(input logic [25:0] a, input logic [3:0] hh, input logic [3:0] ww,
                     input logic wrt, input logic bad);
    int k;
    int t;
    k = 0;
    t = 0;
    grp = 3'($random(seed));
    @(posedge MCLK);
    REQ_ADDR <= a;
    REQ_HEIGHT <= hh;
    REQ_WIDTH <= ww;
    REQ_WRITE <= wrt;
    REQ_GROUP <= grp;
    REQ_VALID <= 1'b1;
    do begin
      @(posedge MCLK);
      t++;
    end while (REQ_READY !== 1'b1 && t < 50);
    REQ_VALID <= 1'b0;
    t = 0;
    while (DONE !== 1'b1 && t < 300) begin
      @(posedge MCLK);
      t++;
      if (MEM_REQ === 1'b1 && MEM_GNT === 1'b1) begin
        chk(MEM_ADDR, {a[25:20] + 6'(k / hh), a[19:0] + 20'(k % hh)});
        chk(MEM_WRITE, wrt);
        k++;
      end
    end
    chk(DONE, 1'b1);
    chk(FAILED_RESULT, bad);
    chk(k, bad ? 0 : hh * ww);
  endtask

  function automatic logic [25:0] xl(input logic [26:0] ba);
    return {MID_SHARED0 + {2'h0, ba[26:25]}, ba[4:3], ba[24:5]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Refused shapes and identifiers: address, height, width.
  initial begin
    bad_tab = '{{4'h3, 22'h0, 8'h11}, {4'h6, 2'h2, 20'h0, 8'h11}, {4'h0, 2'h1, 20'h0, 8'h11},
                {4'h1, 2'h1, 20'h0, 8'h11}, {4'h2, 2'h2, 20'h0, 8'h11}, {4'h1, 22'h0, 8'h12},
                {4'h9, 22'h0, 8'h82}, {4'h9, 22'h1, 8'h21}, {4'h2, 22'h0, 8'h51},
                {4'hB, 2'h3, 20'h0, 8'h12}, {4'hF, 2'h3, 20'h0, 8'h12}};
  end

  // Hang guard, far beyond the few hundred cycles the tests take.
  initial begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end

  // Main sequence.
  initial begin
    repeat (6) @(posedge MCLK);
    RSTN <= 1'b1;
    chk(REQ_READY, 1'b1);
    rd(REG_CTRL, d);
    chk(d, CTRL_RST);
    wr(4'hF, 32'hFFFF_FFFF);
    rd(4'hF, d);
    chk(d, 32'h0);
    rd(REG_CTRL, d);
    chk(d, CTRL_RST);
    $display("test registers done");
    // Offsets aligned to eight keep every walk clear of the bank bits.
    for (int i = 0; i < 20; i++) begin
      h = 4'(($random(seed) & 3) + 1);
      w = 4'(($random(seed) & 1) + 1);
      cmd({MID_DRAM1, 2'h0, 20'($random(seed)) & 20'hFFFF8}, h, w, 1'(i), 1'b0);
    end
    cmd({MID_DRAM0, 2'h0, 20'h10}, 4'h8, 4'h1, 1'b0, 1'b0);
    cmd({MID_DRAM1, 2'h0, 20'h8}, 4'h2, 4'h4, 1'b1, 1'b0);
    cmd({MID_INTERNAL, BANK_NARROW, 20'h8}, 4'h8, 4'h1, 1'b0, 1'b0);
    cmd({MID_ZBT, 2'h0, 20'hFFFF2}, 4'h2, 4'h1, 1'b0, 1'b0);
    cmd({MID_DRAM0, 2'h3, 20'h0}, 4'h1, 4'h2, 1'b0, 1'b0);
    cmd({MID_SHARED0 + 4'h3, 2'h0, 20'h4}, 4'h1, 4'h4, 1'b0, 1'b0);
    // Placement as software keeps it: no top location of a third-DRAM bank.
    cmd({MID_DRAM2, 2'h1, 20'hFFFF0}, 4'h4, 4'h1, 1'b1, 1'b0);
    cmd({MID_DRAM3, 2'h2, 20'h5}, 4'h1, 4'h1, 1'b0, 1'b0);
    cmd({MID_INTERNAL, BANK_WIDE, 20'h4}, 4'h4, 4'h1, 1'b0, 1'b0);
    $display("test walks done");
    step = $random(seed);
    wr(REG_STEPSET, step);
    // Older ZBT depth and double-wide first DRAM: legal and refused shapes.
    wr(REG_CTRL, 32'h1);
    cmd({MID_DRAM0, 2'h3, 20'h0}, 4'h1, 4'h2, 1'b0, 1'b1);
    cmd({MID_DRAM0, 2'h0, 20'h4}, 4'h4, 4'h1, 1'b1, 1'b0);
    cmd({MID_DRAM0, 2'h0, 20'h0}, 4'h4, 4'h2, 1'b0, 1'b1);
    cmd({MID_ZBT, 2'h0, 20'h7FFF8}, 4'h8, 4'h1, 1'b0, 1'b0);
    cmd({MID_ZBT, 2'h0, 20'h80000}, 4'h1, 4'h1, 1'b0, 1'b1);
    for (int i = 0; i < 11; i++) begin
      cmd(bad_tab[i][33:8], bad_tab[i][7:4], bad_tab[i][3:0], 1'b0, 1'b1);
    end
    settle();
    chk(SINGLE_STEP, step);
    chk(IRQ_CLASS3, 1'b0);
    rd(REG_CLASS3, d);
    chk(d & 32'h6, 32'h4);
    wr(REG_MASK3, 32'h4);
    settle();
    chk(IRQ_CLASS3, 1'b1);
    wr(REG_CLASS3, 32'h4);
    settle();
    chk(IRQ_CLASS3, 1'b0);
    chk(SINGLE_STEP, 32'h0);
    $display("test refusals done");
    rng = {MID_DRAM1, 2'h1, 20'h00100};
    wr(REG_MIN, rng);
    wr(REG_MAX, rng);
    wr(REG_CTRL, 32'hA);
    cmd(rng, 4'h1, 4'h1, 1'b0, 1'b0);
    rd(REG_CLASS3, d);
    chk(d & 32'h6, 32'h2);
    rd(REG_BOUNDS, d);
    chk(d, {28'h0, 1'b1, grp});
    wr(REG_CLASS3, 32'h2);
    cmd(rng, 4'h1, 4'h1, 1'b1, 1'b0);
    rd(REG_CLASS3, d);
    chk(d & 32'h6, 32'h0);
    wr(REG_MIN, 32'h0);
    wr(REG_MAX, 32'h03FF_FFFF);
    wr(REG_CTRL, 32'hE);
    for (int i = 0; i < 8; i++) begin
      b = (i == 0) ? 27'h7FF_FFFF : 27'($random(seed));
      @(posedge MCLK);
      BUS_ADDR <= b;
      BUS_VALID <= 1'b1;
      @(posedge MCLK);
      BUS_VALID <= 1'b0;
      #1 chk(BUS_CS_ADDR, xl(b));
      chk(BUS_CS_VALID, 1'b1);
    end
    rd(REG_CLASS3, d);
    chk(d & 32'h2, 32'h0);
    $display("test range done");
    report_and_stop();
  end
endmodule
